/* verilog/scr_pkg.sv */
/*
 * scr_pkg: constants and types of the system control registers.
 * assumes a 32-bit classic wishbone slave with word offsets.
 */
//------------------------------------------------------------
// Summary of operation
// [R1] id high upper nibble holds revision
// [R2] twelve bit part number over both id bytes
// [R3] wakeup bit7 flags timer timeout, read-only
// [R4] writing one to bit6 clears wakeup flag
// [R5] bit5 picks 1 kHz or 32 kHz/32
// [R6] bit4 gates the wakeup interrupt request
// [R7] period code 000 disables, else 8..1024 ticks
// [R8] software parks oscillator in stop with 000 and source 1
// [R9] supply bit7 flags low supply when enabled
// [R10] writing one to bit6 clears supply flag
// [R11] bit5 requests interrupt while supply flag set
// [R12] write-once bit4 forces reset on low supply
// [R13] bit3 keeps detector running during stop
// [R14] write-once bit2 enables the whole detector
// [R15] write-once bits take only first write
// [R16] bit0 enables the reference buffer
// [R17] debug pin enable only clears by software
// [R18] wakeup pending equals flag and enable
// [R19] supply pending equals flag, enable, detector
// [R20] timer counts ticks, flags, restarts; 000 clears
// [R21] reset clears controls, flags and write locks; debug pin enable resets to one
//------------------------------------------------------------
package scr_pkg;

    // register byte offsets
    localparam logic [7:0] SCR_ID_HIGH_OFF = 8'h00;
    localparam logic [7:0] SCR_ID_LOW_OFF  = 8'h04;
    localparam logic [7:0] SCR_WAKE_OFF    = 8'h08;
    localparam logic [7:0] SCR_SUPPLY_OFF  = 8'h0C;
    localparam logic [7:0] SCR_OPTION_OFF  = 8'h10;
    localparam logic [7:0] SCR_PENDING_OFF = 8'h14;

    // identity values, arbitrary
    localparam logic [3:0]  SCR_REVISION = 4'h1;
    localparam logic [11:0] SCR_PART_NUM = 12'h5A3;

    // field positions
    localparam int SCR_FLAG_BIT  = 7;
    localparam int SCR_CLEAR_BIT = 6;
    localparam int SCR_SRC_BIT   = 5;
    localparam int SCR_DEBUG_BIT = 1;

    // reset values
    localparam logic SCR_DEBUG_RST = 1'b1;

    // timing counts
    localparam logic [4:0] SCR_DIV_LAST = 5'h1F;
    localparam logic [9:0] SCR_P1 = 10'h007;
    localparam logic [9:0] SCR_P2 = 10'h01F;
    localparam logic [9:0] SCR_P3 = 10'h03F;
    localparam logic [9:0] SCR_P4 = 10'h07F;
    localparam logic [9:0] SCR_P5 = 10'h0FF;
    localparam logic [9:0] SCR_P6 = 10'h1FF;
    localparam logic [9:0] SCR_P7 = 10'h3FF;

    // wakeup control fields
    typedef struct packed {
        logic       src;
        logic       ie;
        logic [2:0] sel;
    } scr_wake_t;

    // supply monitor control fields
    typedef struct packed {
        logic ie;
        logic re;
        logic se;
        logic de;
        logic bg;
    } scr_supply_t;

endpackage : scr_pkg

/* verilog/scr_top.sv */
/*
 * scr_top: system id, wakeup timer and supply monitor registers.
 * assumes classic wishbone master on clk_i; tick and trip pins
 * are asynchronous and are synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none

module scr_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        tick_1khz_i,
    input  wire logic        clk_32khz_i,
    input  wire logic        trip_i,
    input  wire logic        stop_mode_i,
    output logic             wake_irq_o,
    output logic             supply_irq_o,
    output logic             supply_reset_o,
    output logic             ref_buf_en_o,
    output logic             debug_pin_en_o,
    output logic             osc_1khz_en_o
);
    import scr_pkg::*;

    //--------------------------------------------------------
    // state
    //--------------------------------------------------------
    logic [2:0]  s1k_reg;        // 1 kHz sync and edge
    logic [2:0]  s1k_next;
    logic [2:0]  s32_reg;        // 32 kHz sync and edge
    logic [2:0]  s32_next;
    logic [1:0]  strip_reg;      // trip sync
    logic [1:0]  strip_next;
    logic [4:0]  div_reg;        // divide by 32
    logic [4:0]  div_next;
    logic        div_tick_reg;   // trimmed 1 ms tick
    logic        div_tick_next;
    logic [9:0]  cnt_reg;        // period counter
    logic [9:0]  cnt_next;
    scr_wake_t   wake_reg;       // wakeup control
    scr_wake_t   wake_next;
    logic        wflag_reg;      // timeout flag
    logic        wflag_next;
    scr_supply_t sup_reg;        // supply control
    scr_supply_t sup_next;
    logic        sflag_reg;      // low supply flag
    logic        sflag_next;
    logic        lock_reg;       // write-once lock
    logic        lock_next;
    logic        dbg_reg;        // debug pin enable
    logic        dbg_next;
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic        wirq_reg;
    logic        wirq_next;
    logic        sirq_reg;
    logic        sirq_next;
    logic        srst_reg;
    logic        srst_next;
    logic        osc_reg;
    logic        osc_next;

    //--------------------------------------------------------
    // combinational helpers
    //--------------------------------------------------------
    logic        tick;           // selected tick
    logic [9:0]  last;           // terminal count
    logic        wr;             // write at ack edge
    logic        det_on;         // detector running
    logic        wpend;
    logic        spend;
    logic [7:0]  rd;

    // terminal count for each period code
    always_comb begin
        case (wake_reg.sel)
            3'h1:    last = SCR_P1;   // see [R7]
            3'h2:    last = SCR_P2;
            3'h3:    last = SCR_P3;
            3'h4:    last = SCR_P4;
            3'h5:    last = SCR_P5;
            3'h6:    last = SCR_P6;
            3'h7:    last = SCR_P7;
            default: last = 10'h000;
        endcase
    end

    // pending terms and detector activity
    always_comb begin
        // pending terms
        wpend  = wflag_reg & wake_reg.ie;             // see [R18]
        spend  = sflag_reg & sup_reg.ie & sup_reg.de; // see [R19]
        // enabled detector runs unless stopped without stop enable
        det_on = sup_reg.de & (~stop_mode_i | sup_reg.se); // see [R13]
        // tick source select
        tick   = wake_reg.src ? div_tick_reg : (s1k_reg[1] & ~s1k_reg[2]); // see [R5]
        // write strobe on the low byte lane
        wr     = ack_reg & cyc_i & stb_i & we_i & sel_i[0];
    end

    // read mux
    always_comb begin
        case (adr_i)
            SCR_ID_HIGH_OFF: rd = {SCR_REVISION, SCR_PART_NUM[11:8]}; // see [R1] [R2]
            SCR_ID_LOW_OFF:  rd = SCR_PART_NUM[7:0];                  // see [R2]
            SCR_WAKE_OFF:    rd = {wflag_reg, 1'b0, wake_reg.src,
                                   wake_reg.ie, 1'b0, wake_reg.sel};  // see [R3] [R4]
            SCR_SUPPLY_OFF:  rd = {sflag_reg & sup_reg.de, 1'b0,
                                   sup_reg.ie, sup_reg.re, sup_reg.se,
                                   sup_reg.de, 1'b0, sup_reg.bg};     // see [R9] [R10]
            SCR_OPTION_OFF:  rd = {6'h00, dbg_reg, 1'b0};
            SCR_PENDING_OFF: rd = {6'h00, wpend, spend};
            default:         rd = 8'h00;
        endcase
    end

    //--------------------------------------------------------
    // bus slave
    //--------------------------------------------------------
    // one wait state, ack for any address, unmapped reads zero
    always_comb begin
        ack_next = cyc_i & stb_i & ~ack_reg;
        dat_next = ack_next ? {24'h000000, rd} : 32'h00000000;
    end

    //--------------------------------------------------------
    // tick generation
    //--------------------------------------------------------
    // synchronisers; the first stage feeds only the second
    always_comb begin
        s1k_next      = {s1k_reg[1:0], tick_1khz_i};
        s32_next      = {s32_reg[1:0], clk_32khz_i};
        strip_next    = {strip_reg[0], trip_i};
        div_next      = div_reg;
        div_tick_next = 1'b0;
        // divide 32 kHz rises by 32
        if (s32_reg[1] & ~s32_reg[2]) begin
            div_next      = div_reg + 5'h01;           // see [R5]
            div_tick_next = (div_reg == SCR_DIV_LAST);
        end
    end

    //--------------------------------------------------------
    // wakeup timer
    //--------------------------------------------------------
    always_comb begin
        cnt_next   = cnt_reg;
        wake_next  = wake_reg;
        wflag_next = wflag_reg;
        // software clear first so a timeout wins
        if (wr && adr_i == SCR_WAKE_OFF) begin
            wake_next.src = dat_i[SCR_SRC_BIT];  // see [R5]
            wake_next.ie  = dat_i[4];            // see [R6]
            wake_next.sel = dat_i[2:0];          // see [R7]
            if (dat_i[SCR_CLEAR_BIT]) begin
                wflag_next = 1'b0;               // see [R4]
            end
        end
        // counter held clear while disabled
        if (wake_reg.sel == 3'h0) begin
            cnt_next = 10'h000;                  // see [R20]
        end else if (tick) begin
            if (cnt_reg >= last) begin
                cnt_next   = 10'h000;            // see [R20]
                wflag_next = 1'b1;               // see [R3]
            end else begin
                cnt_next = cnt_reg + 10'h001;
            end
        end
    end

    //--------------------------------------------------------
    // supply monitor and option bit
    //--------------------------------------------------------
    always_comb begin
        sup_next   = sup_reg;
        sflag_next = sflag_reg;
        lock_next  = lock_reg;
        dbg_next   = dbg_reg;
        if (wr && adr_i == SCR_SUPPLY_OFF) begin
            sup_next.ie = dat_i[5];              // see [R11]
            sup_next.se = dat_i[3];              // see [R13]
            sup_next.bg = dat_i[0];              // see [R16]
            // write-once bits take the first write only
            if (!lock_reg) begin
                sup_next.re = dat_i[4];          // see [R12] [R15]
                sup_next.de = dat_i[2];          // see [R14] [R15]
                lock_next   = 1'b1;              // see [R15]
            end
            if (dat_i[SCR_CLEAR_BIT]) begin
                sflag_next = 1'b0;               // see [R10]
            end
        end
        // trip sets the flag only while detecting; set wins
        if (det_on && strip_reg[1]) begin
            sflag_next = 1'b1;                   // see [R9] [R14]
        end
        // debug pin enable can only be cleared
        if (wr && adr_i == SCR_OPTION_OFF && !dat_i[SCR_DEBUG_BIT]) begin
            dbg_next = 1'b0;                     // see [R17]
        end
    end

    //--------------------------------------------------------
    // output requests
    //--------------------------------------------------------
    always_comb begin
        wirq_next = wpend;                       // see [R6]
        sirq_next = spend;                       // see [R11]
        srst_next = sflag_reg & sup_reg.re & sup_reg.de; // see [R12]
        // oscillator parked with 000 and trimmed source in stop
        osc_next  = ~(stop_mode_i & wake_reg.src & (wake_reg.sel == 3'h0));
    end

    //--------------------------------------------------------
    // registers
    //--------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1k_reg      <= 3'h0;
            s32_reg      <= 3'h0;
            strip_reg    <= 2'h0;
            div_reg      <= 5'h00;
            div_tick_reg <= 1'b0;
            cnt_reg      <= 10'h000;
            wake_reg     <= '0;                  // see [R21]
            wflag_reg    <= 1'b0;                // see [R21]
            sup_reg      <= '0;                  // see [R21]
            sflag_reg    <= 1'b0;
            lock_reg     <= 1'b0;                // see [R21]
            dbg_reg      <= SCR_DEBUG_RST;       // see [R17]
            ack_reg      <= 1'b0;
            dat_reg      <= 32'h00000000;
            wirq_reg     <= 1'b0;                // see [R18]
            sirq_reg     <= 1'b0;
            srst_reg     <= 1'b0;
            osc_reg      <= 1'b1;
        end else begin
            s1k_reg      <= s1k_next;
            s32_reg      <= s32_next;
            strip_reg    <= strip_next;
            div_reg      <= div_next;
            div_tick_reg <= div_tick_next;
            cnt_reg      <= cnt_next;
            wake_reg     <= wake_next;
            wflag_reg    <= wflag_next;
            sup_reg      <= sup_next;
            sflag_reg    <= sflag_next;
            lock_reg     <= lock_next;
            dbg_reg      <= dbg_next;
            ack_reg      <= ack_next;
            dat_reg      <= dat_next;
            wirq_reg     <= wirq_next;
            sirq_reg     <= sirq_next;
            srst_reg     <= srst_next;
            osc_reg      <= osc_next;
        end
    end

    // outputs straight from flip-flops
    assign dat_o          = dat_reg;
    assign ack_o          = ack_reg;
    assign wake_irq_o     = wirq_reg;
    assign supply_irq_o   = sirq_reg;
    assign supply_reset_o = srst_reg;
    assign ref_buf_en_o   = sup_reg.bg;
    assign debug_pin_en_o = dbg_reg;
    assign osc_1khz_en_o  = osc_reg;

    //--------------------------------------------------------
    // assertions
    //--------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a wakeup write with the clear bit set
    sequence wclr_s;
        wr && adr_i == SCR_WAKE_OFF && dat_i[SCR_CLEAR_BIT];
    endsequence

    // a tick at the terminal count while enabled
    sequence wdone_s;
        tick && wake_reg.sel != 3'h0 && cnt_reg >= last;
    endsequence

    // no timeout in the same cycle
    sequence wquiet_s;
        !(tick && wake_reg.sel != 3'h0 && cnt_reg >= last);
    endsequence

    // a supply write with the clear bit set
    sequence sclr_s;
        wr && adr_i == SCR_SUPPLY_OFF && dat_i[SCR_CLEAR_BIT];
    endsequence

    // a synchronised trip while the detector runs
    sequence strip_s;
        det_on && strip_reg[1];
    endsequence

    // no trip taken in the same cycle
    sequence squiet_s;
        !(det_on && strip_reg[1]);
    endsequence

    // wakeup timer
    a_wake_timeout: assert property (wdone_s |=> wflag_reg && cnt_reg == 10'h000) // see [R20]
        else $error("timeout did not set flag");
    a_wake_clear: assert property (wclr_s and wquiet_s |=> !wflag_reg) // see [R4]
        else $error("wakeup flag not cleared");
    a_wake_hold: assert property (wake_reg.sel == 3'h0 |=> cnt_reg == 10'h000) // see [R7]
        else $error("counter runs while disabled");
    a_wake_count: assert property ( // see [R20]
        tick && wake_reg.sel != 3'h0 && cnt_reg < last |=> cnt_reg == $past(cnt_reg) + 10'h001)
        else $error("counter did not step");
    a_wake_irq: assert property (##1 wake_irq_o == $past(wflag_reg && wake_reg.ie)) // see [R18]
        else $error("wakeup irq mismatch");
    a_div_tick: assert property (div_tick_reg |-> $past(div_reg, 1) == SCR_DIV_LAST) // see [R5]
        else $error("divider tick early");
    a_div_wrap: assert property ( // see [R5]
        s32_reg[1] && !s32_reg[2] && div_reg == SCR_DIV_LAST |=> div_reg == 5'h00)
        else $error("divider did not wrap");

    // supply monitor
    a_supply_set: assert property (strip_s |=> sflag_reg) // see [R9]
        else $error("trip did not set flag");
    a_supply_clear: assert property (sclr_s and squiet_s |=> !sflag_reg) // see [R10]
        else $error("supply flag not cleared");
    a_supply_gate: assert property (!det_on && !sflag_reg |=> !sflag_reg) // see [R14]
        else $error("flag set while detector off");
    a_supply_irq: assert property ( // see [R11] [R19]
        ##1 supply_irq_o == $past(sflag_reg && sup_reg.ie && sup_reg.de))
        else $error("supply irq mismatch");
    a_supply_reset: assert property ( // see [R12]
        ##1 supply_reset_o == $past(sflag_reg && sup_reg.re && sup_reg.de))
        else $error("reset request mismatch");
    a_once_lock: assert property ( // see [R15]
        lock_reg |=> $stable(sup_reg.de) && $stable(sup_reg.re))
        else $error("write-once bit changed");
    a_lock_first: assert property ( // see [R15]
        wr && adr_i == SCR_SUPPLY_OFF && !lock_reg
        |=> lock_reg && sup_reg.de == $past(dat_i[2]))
        else $error("first write not taken");
    a_ref_buf: assert property ( // see [R16]
        wr && adr_i == SCR_SUPPLY_OFF |=> ref_buf_en_o == $past(dat_i[0]))
        else $error("buffer enable not written");
    a_debug_clear: assert property (!dbg_reg |=> !dbg_reg) // see [R17]
        else $error("debug enable set by software");

    // bus and identity
    a_bus_ack: assert property (cyc_i && stb_i && !ack_reg |=> ack_reg ##1 !ack_reg)
        else $error("ack not single cycle");
    a_read_idle: assert property (!ack_o |-> dat_o == 32'h00000000)
        else $error("read data outside answer");
    a_id_read: assert property ( // see [R1] [R2]
        ack_o && $past(adr_i) == SCR_ID_HIGH_OFF
        |-> dat_o[7:0] == {SCR_REVISION, SCR_PART_NUM[11:8]})
        else $error("identity byte mismatch");

endmodule : scr_top

`default_nettype wire

/* verification/tb_scr_top.sv */
/*
 * tb_scr_top: self-checking bench for the system control registers.
 * assumes scr_pkg offsets, one-cycle registered wishbone ack and
 * 2-ff synchronisers on the tick, 32 kHz and trip inputs.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_scr_top;
    import scr_pkg::*;

    //------------------------------------------------------------
    // signals
    //------------------------------------------------------------
    logic        clk_i;          // 50 MHz system clock
    logic        rst_i;          // synchronous reset
    logic        cyc_i;          // bus cycle
    logic        stb_i;          // bus strobe
    logic        we_i;           // bus direction
    logic [7:0]  adr_i;          // byte address
    logic [3:0]  sel_i;          // byte enables
    logic [31:0] dat_i;          // write data
    logic [31:0] dat_o;          // read data
    logic        ack_o;          // bus answer
    logic        tick_1khz_i;    // slow tick source
    logic        clk_32khz_i;    // trimmed clock source
    logic        trip_i;         // comparator level
    logic        stop_mode_i;    // stop mode level
    logic        wake_irq_o;     // timer request
    logic        supply_irq_o;   // supply request
    logic        supply_reset_o; // supply reset request
    logic        ref_buf_en_o;   // reference buffer
    logic        debug_pin_en_o; // debug pin function
    logic        osc_1khz_en_o;  // slow oscillator power
    int          failures;       // mismatches seen
    int          n_compared;     // comparisons made

    scr_top i_scr_top (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .tick_1khz_i(tick_1khz_i), .clk_32khz_i(clk_32khz_i), .trip_i(trip_i),
        .stop_mode_i(stop_mode_i), .wake_irq_o(wake_irq_o), .supply_irq_o(supply_irq_o),
        .supply_reset_o(supply_reset_o), .ref_buf_en_o(ref_buf_en_o),
        .debug_pin_en_o(debug_pin_en_o), .osc_1khz_en_o(osc_1khz_en_o)
    );

    //------------------------------------------------------------
    // helpers
    //------------------------------------------------------------
    // free-running clock, 20 ns period
    always #10 clk_i = ~clk_i;

    // counts, verdict and end of run
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    // one comparison, reported at once on mismatch
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= wr;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h000000, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 16);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        if (ack_o !== 1'b1) begin
            check({31'h0, ack_o}, 32'h1);
            close_out();
        end
    endtask : wb

    // full-byte write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'h1, q);
    endtask : wr

    // read and compare one register
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, 4'hF, q);
        check(q, {24'h000000, exp});
    endtask : rd

    // let synchronisers and registered outputs settle
    task automatic settle();
        repeat (6) @(posedge clk_i);
    endtask : settle

    // n rising edges on the chosen tick source
    task automatic ticks(input logic src, input int n);
        for (int i = 0; i < n; i++) begin
            if (src) clk_32khz_i <= 1'b1; else tick_1khz_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            if (src) clk_32khz_i <= 1'b0; else tick_1khz_i <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
        settle();
    endtask : ticks

    // synchronous reset for two edges
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask : do_reset

    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    // identity bytes, read-only id, reset values, unmapped place
    task automatic t_reset_values();
        rd(SCR_ID_HIGH_OFF, {SCR_REVISION, SCR_PART_NUM[11:8]});
        rd(SCR_ID_LOW_OFF, SCR_PART_NUM[7:0]);
        wr(SCR_ID_LOW_OFF, 8'hFF);
        rd(SCR_ID_LOW_OFF, SCR_PART_NUM[7:0]);
        rd(SCR_WAKE_OFF, 8'h00);
        rd(SCR_SUPPLY_OFF, 8'h00);
        rd(SCR_OPTION_OFF, 8'h02);
        rd(SCR_PENDING_OFF, 8'h00);
        check({31'h0, osc_1khz_en_o}, 32'h1);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
    endtask : t_reset_values

    // one period code: no flag one tick short, flag on the last tick
    task automatic t_period(input logic [2:0] code, input int n, input logic src);
        int m;
        m = src ? 32 : 1;
        wr(SCR_WAKE_OFF, 8'h00);
        wr(SCR_WAKE_OFF, {2'b11, src, 2'b00, code});
        rd(SCR_WAKE_OFF, {2'b00, src, 2'b00, code});
        ticks(src, m * n - 1);
        rd(SCR_WAKE_OFF, {2'b00, src, 2'b00, code});
        ticks(src, 1);
        rd(SCR_WAKE_OFF, {2'b10, src, 2'b00, code});
    endtask : t_period

    // interrupt gating, clear, disabled timer, oscillator power-down
    task automatic t_wake_irq();
        wr(SCR_WAKE_OFF, 8'h51);
        ticks(1'b0, 8);
        check({31'h0, wake_irq_o}, 32'h1);
        rd(SCR_PENDING_OFF, 8'h02);
        wr(SCR_WAKE_OFF, 8'h11);
        settle();
        rd(SCR_WAKE_OFF, 8'h91);
        wr(SCR_WAKE_OFF, 8'h51);
        settle();
        check({31'h0, wake_irq_o}, 32'h0);
        wr(SCR_WAKE_OFF, 8'h01);
        ticks(1'b0, 8);
        rd(SCR_WAKE_OFF, 8'h81);
        check({31'h0, wake_irq_o}, 32'h0);
        wr(SCR_WAKE_OFF, 8'h40);
        ticks(1'b0, 20);
        rd(SCR_WAKE_OFF, 8'h00);
        stop_mode_i <= 1'b1;
        wr(SCR_WAKE_OFF, 8'h20);
        settle();
        check({31'h0, osc_1khz_en_o}, 32'h0);
        wr(SCR_WAKE_OFF, 8'h00);
        settle();
        check({31'h0, osc_1khz_en_o}, 32'h1);
        stop_mode_i <= 1'b0;
    endtask : t_wake_irq

    // detector gating, write-once lock, stop enable, clear
    task automatic t_supply();
        trip_i <= 1'b1;
        settle();
        rd(SCR_SUPPLY_OFF, 8'h00);
        check({31'h0, supply_reset_o}, 32'h0);
        wr(SCR_SUPPLY_OFF, 8'h3D);
        settle();
        rd(SCR_SUPPLY_OFF, 8'hBD);
        check({29'h0, supply_irq_o, supply_reset_o, ref_buf_en_o}, 32'h7);
        rd(SCR_PENDING_OFF, 8'h01);
        trip_i <= 1'b0;
        settle();
        wr(SCR_SUPPLY_OFF, 8'h40);
        settle();
        rd(SCR_SUPPLY_OFF, 8'h14);
        check({29'h0, supply_irq_o, supply_reset_o, ref_buf_en_o}, 32'h0);
        stop_mode_i <= 1'b1;
        trip_i <= 1'b1;
        settle();
        rd(SCR_SUPPLY_OFF, 8'h14);
        stop_mode_i <= 1'b0;
        settle();
        rd(SCR_SUPPLY_OFF, 8'h94);
        check({30'h0, supply_irq_o, supply_reset_o}, 32'h1);
        trip_i <= 1'b0;
    endtask : t_supply

    // debug pin enable: sel gating, one-way clear
    task automatic t_debug();
        logic [31:0] q;
        wb(1'b1, SCR_OPTION_OFF, 8'h00, 4'h0, q);
        rd(SCR_OPTION_OFF, 8'h02);
        wr(SCR_OPTION_OFF, 8'h00);
        rd(SCR_OPTION_OFF, 8'h00);
        wr(SCR_OPTION_OFF, 8'h02);
        rd(SCR_OPTION_OFF, 8'h00);
        check({31'h0, debug_pin_en_o}, 32'h0);
    endtask : t_debug

    // reset in mid-run frees the lock and restores defaults
    task automatic t_rerun();
        do_reset();
        rd(SCR_SUPPLY_OFF, 8'h00);
        rd(SCR_OPTION_OFF, 8'h02);
        check({31'h0, debug_pin_en_o}, 32'h1);
        wr(SCR_SUPPLY_OFF, 8'h04);
        rd(SCR_SUPPLY_OFF, 8'h04);
        wr(SCR_SUPPLY_OFF, 8'h10);
        rd(SCR_SUPPLY_OFF, 8'h04);
    endtask : t_rerun

    //------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------
    initial begin
        int per[8];
        per = '{0, 8, 32, 64, 128, 256, 512, 1024};
        clk_i = 1'b0;
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 8'h00;
        sel_i = 4'h0;
        dat_i = 32'h0;
        tick_1khz_i = 1'b0;
        clk_32khz_i = 1'b0;
        trip_i = 1'b0;
        stop_mode_i = 1'b0;
        failures = 0;
        n_compared = 0;
        do_reset();
        t_reset_values();
        for (int c = 1; c < 8; c++) begin
            t_period(c[2:0], per[c], 1'b0);
        end
        t_period(3'h1, per[1], 1'b1);
        t_wake_irq();
        t_supply();
        t_debug();
        t_rerun();
        close_out();
    end

endmodule : tb_scr_top

`default_nettype wire
